// ### dv/icg_chk.sv
// concurrent checks on the q-channel and reset wires between both ends
`timescale 1ns/1ps
module icg_chk
  import icg_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wires between the ends
  input wire logic [NCHAN-1:0] qreq_n,
  input wire logic [NCHAN-1:0] qaccept_n,
  input wire logic [NCHAN-1:0] qdeny,
  input wire logic [NCHAN-1:0] qactive,
  input wire logic global_reset_n,
  input wire logic link_layer_reset_n,
  input wire logic stream_if_reset_n
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic [CNT_W-1:0] g_cnt_q;
  logic [CNT_W-1:0] l_cnt_q;
  logic g_prev_q;
  logic l_prev_q;
  // ------------------------------------------------------------
  // reset hold counters, saturating so long runs never wrap
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      g_prev_q <= 1'b0;
      g_cnt_q <= CNT_ZERO;
    end else begin
      g_prev_q <= global_reset_n;
      g_cnt_q <= (global_reset_n != g_prev_q) ? CNT_ZERO :
                 (&g_cnt_q) ? g_cnt_q : g_cnt_q + CNT_ONE;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      l_prev_q <= 1'b0;
      l_cnt_q <= CNT_ZERO;
    end else begin
      l_prev_q <= link_layer_reset_n;
      l_cnt_q <= (link_layer_reset_n != l_prev_q) ? CNT_ZERO :
                 (&l_cnt_q) ? l_cnt_q : l_cnt_q + CNT_ONE;
    end
  end
  property p_greset_hold;
    (global_reset_n != g_prev_q) |-> g_cnt_q >= GLOBAL_HOLD_CYC - CNT_ONE;
  endproperty
  a_greset_hold: assert property (p_greset_hold) else $error("global reset too short");
  property p_lreset_hold;
    (link_layer_reset_n != l_prev_q) |-> l_cnt_q >= LINK_HOLD_CYC - CNT_ONE;
  endproperty
  a_lreset_hold: assert property (p_lreset_hold) else $error("link reset too short");
  property p_mesh_order;
    disable iff (rst_i || !global_reset_n || !link_layer_reset_n)
    $fell(qreq_n[CH_MESH]) |-> !qreq_n[CH_LINK] && !qaccept_n[CH_LINK];
  endproperty
  a_mesh_order: assert property (p_mesh_order) else $error("mesh stop with link up");
  // ------------------------------------------------------------
  // per-channel handshake
  // ------------------------------------------------------------
  for (genvar c = 0; c < NCHAN; c++) begin : g_ch
    logic rn;
    assign rn = (c == CH_MESH) ? global_reset_n :
                (c == CH_LINK) ? link_layer_reset_n : stream_if_reset_n;
    sequence s_req_idle;
      $fell(qreq_n[c]) && !qactive[c] && qaccept_n[c];
    endsequence
    sequence s_req_busy;
      $fell(qreq_n[c]) && qactive[c] && qaccept_n[c];
    endsequence
    property p_accept;
      disable iff (rst_i || !rn) s_req_idle |=> !qaccept_n[c] && !qdeny[c];
    endproperty
    a_accept: assert property (p_accept) else $error("idle request not accepted");
    property p_deny;
      disable iff (rst_i || !rn) s_req_busy |=> qdeny[c] && qaccept_n[c];
    endproperty
    a_deny: assert property (p_deny) else $error("busy request not denied");
    property p_acc_hold;
      disable iff (rst_i || !rn) !qreq_n[c] && !qaccept_n[c] |=> !qaccept_n[c];
    endproperty
    a_acc_hold: assert property (p_acc_hold) else $error("accept dropped early");
    property p_deny_hold;
      disable iff (rst_i || !rn) !qreq_n[c] && qdeny[c] |=> qdeny[c];
    endproperty
    a_deny_hold: assert property (p_deny_hold) else $error("deny dropped early");
    property p_excl;
      disable iff (rst_i || !rn) !(qdeny[c] && !qaccept_n[c]);
    endproperty
    a_excl: assert property (p_excl) else $error("accept and deny together");
    property p_wake;
      disable iff (rst_i || !rn) $rose(qreq_n[c]) && !qaccept_n[c] |-> ##[1:5] qaccept_n[c];
    endproperty
    a_wake: assert property (p_wake) else $error("wake not answered");
    property p_deny_drop;
      disable iff (rst_i || !rn) $rose(qreq_n[c]) && qdeny[c] |=> !qdeny[c];
    endproperty
    a_deny_drop: assert property (p_deny_drop) else $error("deny not withdrawn");
    property p_req_hold;
      disable iff (rst_i || !rn) !qreq_n[c] && qaccept_n[c] && !qdeny[c] |=> !qreq_n[c];
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request withdrawn early");
  end
endmodule

// ### dv/idle_clock_gating_reset_ctrl_tb_top.sv
// self-checking bench joining the interconnect end and the controller end
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
`define WT(cond, n) for (int k = 0; k < (n) && !(cond); k++) @(negedge clk_i);
module idle_clock_gating_reset_ctrl_tb_top
  import icg_pkg::*;
;
  // set before any process starts, so no false edge at time zero
  logic clk_i = 1'b0;
  logic rst_i;
  logic gating_enable_i;
  logic [NCHAN-1:0] busy_i;
  logic [NCHAN-1:0] reset_req_i;
  logic [NCHAN-1:0] chan_run_o;
  logic [NCHAN-1:0] dom_ready_o;
  logic [NCHAN-1:0] chan_stopped_o;
  logic [NDOM-1:0] mesh_clk_en_o;
  logic stream_async_o;
  logic link_clk_en_o;
  logic stream_clk_en_o;
  logic link_ready_o;
  logic s_async;
  logic [NDOM-1:0] s_mesh_en;
  logic s_link_en;
  logic s_stream_en;
  int errors;
  int n_compared;
  int cnt;
  logic ok;
  icg_qch_if qch ();
  icg_dev u_icg_dev (.clk_i(clk_i), .rst_i(rst_i), .qch(qch), .busy_i(busy_i),
    .chan_run_o(chan_run_o), .dom_ready_o(dom_ready_o), .stream_async_o(stream_async_o));
  icg_ctrl u_icg_ctrl (.clk_i(clk_i), .rst_i(rst_i), .qch(qch),
    .gating_enable_i(gating_enable_i), .reset_req_i(reset_req_i),
    .mesh_clk_en_o(mesh_clk_en_o), .link_clk_en_o(link_clk_en_o),
    .stream_clk_en_o(stream_clk_en_o), .chan_stopped_o(chan_stopped_o),
    .link_ready_o(link_ready_o));
  icg_chk u_icg_chk (.clk_i(clk_i), .rst_i(rst_i), .qreq_n(qch.qreq_n),
    .qaccept_n(qch.qaccept_n), .qdeny(qch.qdeny), .qactive(qch.qactive),
    .global_reset_n(qch.global_reset_n), .link_layer_reset_n(qch.link_layer_reset_n),
    .stream_if_reset_n(qch.stream_if_reset_n));
  // ------------------------------------------------------------
  // second pair built with a synchronous stream clock
  // ------------------------------------------------------------
  if (1) begin : g_sync
    icg_qch_if qch ();
    icg_dev #(.DOMAIN_BRIDGE_PRESENT(1'b0)) u_icg_dev (.clk_i(clk_i), .rst_i(rst_i), .qch(qch),
      .busy_i(busy_i), .chan_run_o(), .dom_ready_o(), .stream_async_o(s_async));
    icg_ctrl #(.DOMAIN_BRIDGE_PRESENT(1'b0)) u_icg_ctrl (.clk_i(clk_i), .rst_i(rst_i), .qch(qch),
      .gating_enable_i(gating_enable_i), .reset_req_i(reset_req_i),
      .mesh_clk_en_o(s_mesh_en), .link_clk_en_o(s_link_en), .stream_clk_en_o(s_stream_en),
      .chan_stopped_o(), .link_ready_o());
  end
  function automatic logic all_eq(input logic [NDOM-1:0] v);
    return (v == 4'h0) || (v == 4'hF);
  endfunction
  function automatic logic stop_ok(input logic mesh, input logic link);
    return mesh || !link;
  endfunction
  task automatic stop_test();
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    stop_test();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    errors = 0;
    n_compared = 0;
    rst_i = 1'b1;
    busy_i = 3'h7;
    gating_enable_i = 1'b0;
    reset_req_i = 3'h0;
    cnt = $urandom(52);
    repeat (3) @(negedge clk_i);
    rst_i = 1'b0;
    cnt = 0;
    ok = 1'b1;
    while (qch.global_reset_n !== 1'b1 && cnt < 200) begin
      ok &= (&mesh_clk_en_o) & link_clk_en_o & stream_clk_en_o;
      @(negedge clk_i);
      cnt++;
    end
    `CHK("global reset cycles", 1'b1, cnt >= 90)
    repeat (90) begin
      ok &= (&mesh_clk_en_o) & link_clk_en_o & stream_clk_en_o;
      @(negedge clk_i);
    end
    `CHK("clocks around reset", 1'b1, ok)
    `WT(chan_run_o === 3'h7, 100)
    `CHK("boot run", 3'h7, chan_run_o)
    `CHK("run handshake", 3'h7, qch.qaccept_n)
    `CHK("stream relation", 1'b1, stream_async_o)
    `CHK("sync stream relation", 1'b0, s_async)
    // idle must last before any stop request
    busy_i = 3'h0;
    gating_enable_i = 1'b1;
    repeat (60) begin
      @(negedge clk_i);
      `CHK("early stop", 3'h7, qch.qreq_n)
    end
    `WT(chan_stopped_o === 3'h7, 400)
    `CHK("all stopped", 3'h7, chan_stopped_o)
    `CHK("stop handshake", 6'h0, {qch.qreq_n, qch.qaccept_n})
    repeat (3) @(negedge clk_i);
    `CHK("gated clocks", 6'h0, {mesh_clk_en_o, link_clk_en_o, stream_clk_en_o})
    busy_i = 3'h1;
    @(negedge clk_i);
    `CHK("qactive", 3'h1, qch.qactive)
    `WT(mesh_clk_en_o === 4'hF, 20)
    `CHK("mesh wake", 5'h1F, {chan_run_o[0], mesh_clk_en_o})
    // busy rising just as a stop request lands
    busy_i[2] = 1'b1;
    `WT(chan_run_o[2] === 1'b1, 50)
    busy_i[2] = 1'b0;
    `WT(qch.qreq_n[2] === 1'b0, 200)
    busy_i[2] = 1'b1;
    @(negedge clk_i);
    `CHK("deny on busy", 1'b1, qch.qdeny[2])
    `WT(chan_run_o[2] === 1'b1 && qch.qdeny[2] === 1'b0, 20)
    `CHK("back to run", 2'b10, {chan_run_o[2], qch.qdeny[2]})
    busy_i = 3'h0;
    reset_req_i[1] = 1'b1;
    @(negedge clk_i);
    reset_req_i[1] = 1'b0;
    `WT(qch.link_layer_reset_n === 1'b0, 5)
    cnt = 0;
    ok = 1'b1;
    while (qch.link_layer_reset_n !== 1'b1 && cnt < 100) begin
      ok &= link_clk_en_o & ~dom_ready_o[1];
      @(negedge clk_i);
      cnt++;
    end
    `CHK("link reset cycles", 1'b1, cnt >= 20)
    repeat (20) begin
      ok &= link_clk_en_o;
      @(negedge clk_i);
    end
    `CHK("link clock in reset", 1'b1, ok)
    `WT(dom_ready_o[1] === 1'b1 && link_ready_o === 1'b1, 50)
    `CHK("link ready", 2'b11, {dom_ready_o[1], link_ready_o})
    // bursty random load with long idle gaps
    repeat (3000) begin
      if ($urandom % 64 == 0) busy_i = ($urandom % 2) ? 3'($urandom) : 3'h0;
      if ($urandom % 300 == 0) gating_enable_i = ~gating_enable_i;
      @(negedge clk_i);
      `CHK("qactive", busy_i, qch.qactive)
      `CHK("mesh en equal", 1'b1, all_eq(mesh_clk_en_o))
      `CHK("mesh vs link", 1'b1, stop_ok(mesh_clk_en_o[0], link_clk_en_o))
      `CHK("sync stream copy", 1'b1, s_link_en === s_stream_en)
      `CHK("sync mesh vs link", 1'b1, stop_ok(s_mesh_en[0], s_link_en))
      `CHK("sync mesh en equal", 1'b1, all_eq(s_mesh_en))
    end
    stop_test();
  end
endmodule

// ### logic/icg_ctrl.sv
// external clock controller end: reset sequencing, idle hysteresis, clock stop policy
`timescale 1ns/1ps
module icg_ctrl
  import icg_pkg::*;
#(
  parameter bit DOMAIN_BRIDGE_PRESENT = 1'b1
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to the interconnect
  icg_qch_if.ctrl qch,
  // policy and reset requests
  input wire logic gating_enable_i,
  input wire logic [NCHAN-1:0] reset_req_i,
  // clock gate enables
  output logic [NDOM-1:0] mesh_clk_en_o,
  output logic link_clk_en_o,
  output logic stream_clk_en_o,
  // status
  output logic [NCHAN-1:0] chan_stopped_o,
  output logic link_ready_o
);

  // ------------------------------------------------------------
  // per-channel state
  // ------------------------------------------------------------
  icg_hstate_t st_q [NCHAN];
  logic [NCHAN-1:0] qreq_n_q;
  logic [NCHAN-1:0] boot_q;
  logic [CNT_W-1:0] idle_q [NCHAN];
  logic [NCHAN-1:0] rst_n_q;
  logic [NCHAN-1:0] hold_done_q;
  logic [CNT_W-1:0] rcnt_q [NCHAN];
  logic [NCHAN-1:0] stopped;
  logic [NCHAN-1:0] want;
  logic [NCHAN-1:0] pull;
  logic [NCHAN-1:0] up_run;
  logic [NCHAN-1:0] stop_ok;
  logic [NCHAN-1:0] clk_on;
  logic [NDOM-1:0] mesh_en_q;
  logic link_en_q;
  logic stream_en_q;
  logic link_ready_q;

  function automatic logic [CNT_W-1:0] hold_of(input int ch);
    return (ch == CH_MESH) ? GLOBAL_HOLD_CYC : LINK_HOLD_CYC;
  endfunction

  // ------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------
  // a new request is ignored until the release hold has run out
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_n_q <= '0;
      hold_done_q <= '0;
      for (int i = 0; i < NCHAN; i++) begin
        rcnt_q[i] <= CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        if (!rst_n_q[i]) begin
          if (rcnt_q[i] == hold_of(i) - CNT_ONE) begin
            rst_n_q[i] <= 1'b1;
            rcnt_q[i] <= CNT_ZERO;
          end else begin
            rcnt_q[i] <= rcnt_q[i] + CNT_ONE;
          end
        end else if (!hold_done_q[i]) begin
          if (rcnt_q[i] == hold_of(i) - CNT_ONE) begin
            hold_done_q[i] <= 1'b1;
            rcnt_q[i] <= CNT_ZERO;
          end else begin
            rcnt_q[i] <= rcnt_q[i] + CNT_ONE;
          end
        end else if (reset_req_i[i]) begin
          rst_n_q[i] <= 1'b0;
          hold_done_q[i] <= 1'b0;
          rcnt_q[i] <= CNT_ZERO;
        end
      end
    end
  end

  assign qch.global_reset_n = rst_n_q[CH_MESH];
  assign qch.link_layer_reset_n = rst_n_q[CH_LINK];
  assign qch.stream_if_reset_n = rst_n_q[CH_STREAM];

  // ------------------------------------------------------------
  // ordering between channels
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      stopped[i] = (st_q[i] == HS_STOPPED);
      want[i] = stopped[i] & (qch.qactive[i] | ~gating_enable_i | boot_q[i]);
    end
    // the mesh clock must be up before the link layer wakes
    up_run[CH_MESH] = 1'b1;
    up_run[CH_LINK] = (st_q[CH_MESH] == HS_RUN);
    up_run[CH_STREAM] = DOMAIN_BRIDGE_PRESENT | (st_q[CH_LINK] == HS_RUN);
    pull[CH_STREAM] = 1'b0;
    pull[CH_LINK] = ~DOMAIN_BRIDGE_PRESENT & want[CH_STREAM];
    pull[CH_MESH] = want[CH_LINK] | pull[CH_LINK];
    stop_ok[CH_MESH] = stopped[CH_LINK];
    stop_ok[CH_LINK] = DOMAIN_BRIDGE_PRESENT | stopped[CH_STREAM];
    stop_ok[CH_STREAM] = 1'b1;
  end

  // ------------------------------------------------------------
  // idle hysteresis
  // ------------------------------------------------------------
  // short lulls never reach the threshold, so the mesh keeps its clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < NCHAN; i++) begin
        idle_q[i] <= CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        if (qch.qactive[i] || st_q[i] != HS_RUN) begin
          idle_q[i] <= CNT_ZERO;
        end else if (idle_q[i] != IDLE_HYST_CYC) begin
          idle_q[i] <= idle_q[i] + CNT_ONE;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // q-channel requesters
  // ------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      qreq_n_q <= '0;
      boot_q <= '1;
      for (int i = 0; i < NCHAN; i++) begin
        st_q[i] <= HS_STOPPED;
      end
    end else begin
      for (int i = 0; i < NCHAN; i++) begin
        if (!rst_n_q[i] ||
            (i == CH_STREAM && !DOMAIN_BRIDGE_PRESENT && !rst_n_q[CH_LINK])) begin
          // device side sits stopped while its domain is in reset
          // a synchronous stream domain is held in reset by the link layer too
          st_q[i] <= HS_STOPPED;
          qreq_n_q[i] <= 1'b0;
          boot_q[i] <= 1'b1;
        end else begin
          unique case (st_q[i])
            HS_STOPPED: begin
              if ((want[i] || pull[i]) && up_run[i]) begin
                qreq_n_q[i] <= 1'b1;
                st_q[i] <= HS_EXIT;
              end
            end
            HS_EXIT: begin
              if (qch.qaccept_n[i]) begin
                boot_q[i] <= 1'b0;
                st_q[i] <= HS_RUN;
              end
            end
            HS_RUN: begin
              if (gating_enable_i && idle_q[i] == IDLE_HYST_CYC && stop_ok[i] &&
                  hold_done_q[i] && !pull[i]) begin
                qreq_n_q[i] <= 1'b0;
                st_q[i] <= HS_REQ;
              end
            end
            HS_REQ: begin
              if (!qch.qaccept_n[i]) begin
                st_q[i] <= HS_STOPPED;
              end else if (qch.qdeny[i]) begin
                qreq_n_q[i] <= 1'b1;
                st_q[i] <= HS_DENY_EXIT;
              end
            end
            HS_DENY_EXIT: begin
              if (!qch.qdeny[i]) begin
                st_q[i] <= HS_RUN;
              end
            end
          endcase
        end
      end
    end
  end

  assign qch.qreq_n = qreq_n_q;

  // ------------------------------------------------------------
  // clock gate enables
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      // every clock runs through a global reset and its release hold;
      // a pending request turns the clock on with the reset edge, not one behind it
      clk_on[i] = ~stopped[i] | ~rst_n_q[i] | ~hold_done_q[i] | reset_req_i[i] |
                  ~rst_n_q[CH_MESH] | ~hold_done_q[CH_MESH] |
                  reset_req_i[CH_MESH];
    end
  end

  // a synchronous stream clock is a copy of the link layer clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mesh_en_q <= '1;
      link_en_q <= 1'b1;
      stream_en_q <= 1'b1;
    end else begin
      stream_en_q <= DOMAIN_BRIDGE_PRESENT ? clk_on[CH_STREAM] :
                     clk_on[CH_LINK] | clk_on[CH_STREAM];
      link_en_q <= clk_on[CH_LINK] | (~DOMAIN_BRIDGE_PRESENT & clk_on[CH_STREAM]);
      mesh_en_q <= {NDOM{clk_on[CH_MESH] | clk_on[CH_LINK]}};
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_ready_q <= 1'b0;
    end else begin
      link_ready_q <= &{rst_n_q[CH_LINK], rst_n_q[CH_STREAM],
                        hold_done_q[CH_LINK], hold_done_q[CH_STREAM]};
    end
  end

  assign mesh_clk_en_o = mesh_en_q;
  assign link_clk_en_o = link_en_q;
  assign stream_clk_en_o = stream_en_q;
  assign link_ready_o = link_ready_q;

  always_comb begin
    for (int i = 0; i < NCHAN; i++) begin
      chan_stopped_o[i] = stopped[i];
    end
  end

endmodule

// ### logic/icg_dev.sv
// interconnect end: reset intake and the three clock q-channel responders
`timescale 1ns/1ps
module icg_dev
  import icg_pkg::*;
#(
  parameter bit DOMAIN_BRIDGE_PRESENT = 1'b1
)(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link to the clock controller
  icg_qch_if.dev qch,
  // user side
  input wire logic [NCHAN-1:0] busy_i,
  output logic [NCHAN-1:0] chan_run_o,
  output logic [NCHAN-1:0] dom_ready_o,
  output logic stream_async_o
);

  // ------------------------------------------------------------
  // reset intake
  // ------------------------------------------------------------
  logic [NCHAN-1:0] pin_rst_n;
  logic [NCHAN-1:0] arst;
  logic [NCHAN-1:0] rel_q;
  logic [NCHAN-1:0] dom_rst;

  assign pin_rst_n = {qch.stream_if_reset_n, qch.link_layer_reset_n, qch.global_reset_n};

  // assert at once, release through three stages and a release flop so a pin edge at any time is safe
  for (genvar i = 0; i < NCHAN; i++) begin : g_rst
    logic [SYNC_STAGES-1:0] s_q;
    logic rel_one_q;
    assign arst[i] = rst_i | ~pin_rst_n[i];
    always_ff @(posedge clk_i or posedge arst[i]) begin
      if (arst[i]) begin
        s_q <= '0;
        rel_one_q <= 1'b0;
      end else begin
        s_q <= {s_q[SYNC_STAGES-2:0], 1'b1};
        rel_one_q <= s_q[SYNC_STAGES-2] & s_q[SYNC_STAGES-1];
      end
    end
    // one driving process per bit keeps the release flags single-sourced
    assign rel_q[i] = rel_one_q;
  end

  // synchronous stream logic shares the link layer clock, so it shares its reset
  assign dom_rst[CH_MESH] = ~rel_q[CH_MESH];
  assign dom_rst[CH_LINK] = ~rel_q[CH_LINK];
  assign dom_rst[CH_STREAM] = DOMAIN_BRIDGE_PRESENT ? ~rel_q[CH_STREAM] :
                              ~(rel_q[CH_STREAM] & rel_q[CH_LINK]);

  // ------------------------------------------------------------
  // responders: mesh, link layer, stream
  // ------------------------------------------------------------
  for (genvar i = 0; i < NCHAN; i++) begin : g_ch
    icg_qch_resp u_resp (
      .clk_i(clk_i),
      .rst_i(dom_rst[i]),
      .qreq_n_i(qch.qreq_n[i]),
      .qaccept_n_o(qch.qaccept_n[i]),
      .qdeny_o(qch.qdeny[i]),
      .qactive_o(qch.qactive[i]),
      .busy_i(busy_i[i]),
      .run_o(chan_run_o[i])
    );
  end

  assign dom_ready_o = ~dom_rst;
  assign stream_async_o = DOMAIN_BRIDGE_PRESENT;

endmodule

// ### logic/icg_pkg.sv
// constants and state types shared by both ends of the idle clock gating link
package icg_pkg;

  // ------------------------------------------------------------
  // channels and domains
  // ------------------------------------------------------------
  localparam int NCHAN = 3;
  localparam int CH_MESH = 0;
  localparam int CH_LINK = 1;
  localparam int CH_STREAM = 2;
  localparam int NDOM = 4;
  localparam int SYNC_STAGES = 3;

  // ------------------------------------------------------------
  // timing counts, in clk_i cycles
  // ------------------------------------------------------------
  localparam int CNT_W = 7;
  localparam logic [CNT_W-1:0] GLOBAL_HOLD_CYC = 7'h5A; // 90
  localparam logic [CNT_W-1:0] LINK_HOLD_CYC = 7'h14; // 20
  localparam logic [CNT_W-1:0] IDLE_HYST_CYC = 7'h40; // 64
  localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;

  // ------------------------------------------------------------
  // state types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    DS_RUN,
    DS_STOPPED,
    DS_DENIED
  } icg_dstate_t;

  typedef enum logic [2:0] {
    HS_STOPPED,
    HS_EXIT,
    HS_RUN,
    HS_REQ,
    HS_DENY_EXIT
  } icg_hstate_t;

endpackage

// ### logic/icg_qch_if.sv
// q-channels and resets between the interconnect and its external clock controller
`timescale 1ns/1ps
interface icg_qch_if;
  import icg_pkg::*;

  logic [NCHAN-1:0] qreq_n;
  logic [NCHAN-1:0] qaccept_n;
  logic [NCHAN-1:0] qdeny;
  logic [NCHAN-1:0] qactive;
  logic global_reset_n;
  logic link_layer_reset_n;
  logic stream_if_reset_n;

  modport dev (
    input qreq_n,
    input global_reset_n,
    input link_layer_reset_n,
    input stream_if_reset_n,
    output qaccept_n,
    output qdeny,
    output qactive
  );

  modport ctrl (
    output qreq_n,
    output global_reset_n,
    output link_layer_reset_n,
    output stream_if_reset_n,
    input qaccept_n,
    input qdeny,
    input qactive
  );
endinterface

// ### logic/icg_qch_resp.sv
// one device-side q-channel responder
`timescale 1ns/1ps
module icg_qch_resp
  import icg_pkg::*;
(
  // clock and domain reset
  input wire logic clk_i,
  input wire logic rst_i,
  // channel
  input wire logic qreq_n_i,
  output logic qaccept_n_o,
  output logic qdeny_o,
  output logic qactive_o,
  // user side
  input wire logic busy_i,
  output logic run_o
);

  icg_dstate_t st_q;
  logic qaccept_n_q;
  logic qdeny_q;

  // reset leaves the channel stopped; the controller must wake it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= DS_STOPPED;
      qaccept_n_q <= 1'b0;
      qdeny_q <= 1'b0;
    end else begin
      unique case (st_q)
        DS_RUN: begin
          if (!qreq_n_i && busy_i) begin
            qdeny_q <= 1'b1;
            st_q <= DS_DENIED;
          end else if (!qreq_n_i) begin
            qaccept_n_q <= 1'b0;
            st_q <= DS_STOPPED;
          end
        end
        DS_STOPPED: begin
          if (qreq_n_i) begin
            qaccept_n_q <= 1'b1;
            st_q <= DS_RUN;
          end
        end
        DS_DENIED: begin
          if (qreq_n_i) begin
            qdeny_q <= 1'b0;
            st_q <= DS_RUN;
          end
        end
        default: st_q <= DS_STOPPED;
      endcase
    end
  end

  assign qaccept_n_o = qaccept_n_q;
  assign qdeny_o = qdeny_q;
  assign qactive_o = busy_i;
  assign run_o = (st_q == DS_RUN);

endmodule
